// file: hdl/halfbridge_protection_status.sv
// Purpose: protection and diagnostic status logic of a serially
//   controlled triple half-bridge driver
// Assumes: comparator and sleep inputs are asynchronous; the serial
//   clock is a separate domain owned by the controller
// Notes: result data is shifted out from the core domain so that the
//   prewarning bit can appear before any serial clock edge
// Operation
// - prewarning flag follows set/reset temperature comparator
// - prewarning readable without full 16-bit frame
// - chip select fall presents prewarning flag
// - short frame aborts, registers stay unchanged
// - thermal shutdown turns off all outputs
// - re-enable needs cool die plus reset request
// - current regulator always limits output current
// - overcurrent shutdown only with enable bit high
// - overcurrent shutdown only after delay time
// - overcurrent shutdown sets flag, clears switch status
// - disabled shutdown still flags, keeps outputs
// - reset request clears flag, re-enables outputs
// - sleep pin low turns outputs off, tristate
// - entering sleep erases status register
// - sleep release starts internal power-on reset
// - power-on control: shutdown enabled, switches off
// - prewarning flag at status bit 0
// - short-circuit flag at status bit 13
module halfbridge_protection_status
  import hb_prot_pkg::*;
#(
  parameter int SD_CYC = SD_DELAY_CYC,
  parameter int POR_CYC = POR_DELAY_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ser_clk,
  input wire logic chip_sel_n,
  input wire logic ser_din,
  output logic ser_dout,
  output logic ser_dout_oe_n,
  input wire logic sleep_control_pin,
  input wire logic prewarn_cmp,
  input wire logic shutdown_cmp,
  input wire logic [NUM_SW-1:0] overcurrent_cmp,
  output logic [NUM_SW-1:0] switch_on,
  output logic stage_drive_en,
  output logic current_limit_en
);

  // ---------------- serial clock domain ----------------
  logic [FRAME_BITS-1:0] rx_word_ff;
  logic bit_tgl_ff;

  always_ff @(posedge ser_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_word_ff <= 16'h0000;
      bit_tgl_ff <= 1'b0;
    end else if (!chip_sel_n) begin
      // first bit in lands in bit 0 after sixteen shifts
      rx_word_ff <= {ser_din, rx_word_ff[FRAME_BITS-1:1]};
      bit_tgl_ff <= ~bit_tgl_ff;
    end
  end

  // ---------------- synchronisers ----------------
  localparam int NSYNC = 3 + NUM_SW;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  // chip select and the bit toggle stay out of this bank: an xor of
  // two unrelated signals ahead of a synchroniser could glitch
  wire [NSYNC-1:0] async_in = {overcurrent_cmp, shutdown_cmp,
                               prewarn_cmp, sleep_control_pin};

  // first stage feeds only the second stage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= async_in;
      sync2_ff <= sync1_ff;
    end
  end

  // chip select and the serial bit toggle, each through a pair of its
  // own; the toggle changes once per serial bit, never faster
  logic [1:0] cs_s_ff;
  logic [1:0] tg_s_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s_ff <= 2'b11;
      tg_s_ff <= 2'b00;
    end else begin
      cs_s_ff <= {cs_s_ff[0], chip_sel_n};
      tg_s_ff <= {tg_s_ff[0], bit_tgl_ff};
    end
  end

  wire sleep_s = sync2_ff[0];
  wire warn_s = sync2_ff[1];
  wire shut_s = sync2_ff[2];
  wire [NUM_SW-1:0] oc_s = sync2_ff[NSYNC-1:3];
  wire cs_s = cs_s_ff[1];
  wire tg_s = tg_s_ff[1];

  // ---------------- frame tracking ----------------
  logic cs_prev_ff;
  logic tg_prev_ff;
  logic [BIT_CNT_W-1:0] bit_cnt_ff;

  wire cs_fall = cs_prev_ff & ~cs_s;
  wire cs_rise = ~cs_prev_ff & cs_s;
  // one edge per serial bit; at 2 MHz this leaves over twelve core
  // cycles between edges, which the two-stage path needs
  wire bit_evt = tg_s ^ tg_prev_ff;
  wire [BIT_CNT_W-1:0] cnt_inc = bit_cnt_ff + 5'h01;
  wire cnt_full = (bit_cnt_ff == 5'(FRAME_BITS));
  wire frame_ok = cs_rise & cnt_full;

  // ---------------- power state ----------------
  typedef enum logic [1:0] {
    PWR_SLEEP = 2'b00,
    PWR_POR = 2'b01,
    PWR_RUN = 2'b10
  } pwr_e;

  pwr_e pwr_ff;
  pwr_e nxt_pwr;
  logic [POR_CNT_W-1:0] por_cnt_ff;

  wire por_done = (por_cnt_ff == POR_CNT_W'(POR_CYC));
  wire awake = (pwr_ff == PWR_RUN);

  always_comb begin
    nxt_pwr = pwr_ff;
    case (pwr_ff)
      PWR_SLEEP: if (sleep_s) nxt_pwr = PWR_POR;
      PWR_POR: begin
        if (!sleep_s) nxt_pwr = PWR_SLEEP;
        else if (por_done) nxt_pwr = PWR_RUN;
      end
      PWR_RUN: if (!sleep_s) nxt_pwr = PWR_SLEEP;
      default: nxt_pwr = PWR_SLEEP;
    endcase
  end

  // ---------------- control and status registers ----------------
  logic [FRAME_BITS-1:0] ctrl_ff;
  logic tp_ff;
  logic scd_ff;
  logic tsd_ff;
  logic [NUM_SW-1:0] oc_off_ff;
  logic [NUM_SW-1:0] sd_hit;

  wire srr_wr = frame_ok & awake & rx_word_ff[CT_SRR_BIT];
  wire ocs_en = ctrl_ff[CT_OCS_BIT];
  wire [NUM_SW-1:0] sw_cmd = ctrl_ff[CT_SW_LSB +: NUM_SW];
  wire in_reset = (pwr_ff != PWR_RUN);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_ff <= PWR_SLEEP;
      por_cnt_ff <= '0;
      cs_prev_ff <= 1'b1;
      tg_prev_ff <= 1'b0;
      bit_cnt_ff <= '0;
    end else begin
      pwr_ff <= nxt_pwr;
      por_cnt_ff <= (pwr_ff == PWR_POR && !por_done) ?
                    por_cnt_ff + POR_CNT_W'(1) : '0;
      cs_prev_ff <= cs_s;
      tg_prev_ff <= tg_s;
      if (cs_fall) bit_cnt_ff <= '0;
      else if (bit_evt && !cnt_full) bit_cnt_ff <= cnt_inc;
      // a seventeenth edge sets the count to 5'h1F, refusing the frame; an eighteenth wraps it to zero
      else if (bit_evt) bit_cnt_ff <= 5'h1F;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= CTRL_RST;
    end else if (in_reset) begin
      // frames ending in sleep or power-on reset are dropped
      ctrl_ff <= CTRL_RST;
    end else if (frame_ok) begin
      // the shift register is read only after chip select has risen
      // and passed its synchroniser; the serial clock is still by then
      ctrl_ff <= rx_word_ff;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tp_ff <= 1'b0;
    end else if (in_reset) begin
      tp_ff <= 1'b0;
    end else begin
      // comparator carries the set/reset hysteresis itself
      tp_ff <= warn_s;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tsd_ff <= 1'b0;
    end else if (in_reset) begin
      tsd_ff <= 1'b0;
    end else if (shut_s) begin
      tsd_ff <= 1'b1;
    end else if (srr_wr) begin
      tsd_ff <= 1'b0;
    end
  end

  // per-switch shutdown delay: the current must stay above threshold
  // for the whole delay before the stage is taken off
  generate
    for (genvar i = 0; i < NUM_SW; i++) begin : g_sd
      logic [SD_CNT_W-1:0] sd_cnt_ff;
      wire sd_full = (sd_cnt_ff == SD_CNT_W'(SD_CYC));
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          sd_cnt_ff <= '0;
        end else if (!oc_s[i] || in_reset) begin
          sd_cnt_ff <= '0;
        end else if (!sd_full) begin
          sd_cnt_ff <= sd_cnt_ff + SD_CNT_W'(1);
        end
      end
      assign sd_hit[i] = sd_full & oc_s[i];
    end
  endgenerate

  wire [NUM_SW-1:0] oc_trip = sd_hit & {NUM_SW{ocs_en}};
  wire any_oc = |sd_hit;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_off_ff <= '0;
      scd_ff <= 1'b0;
    end else if (in_reset) begin
      oc_off_ff <= '0;
      scd_ff <= 1'b0;
    end else begin
      // a new trip in the clearing cycle is kept: set wins over clear
      oc_off_ff <= (srr_wr ? '0 : oc_off_ff) | oc_trip;
      scd_ff <= (scd_ff & ~srr_wr) | any_oc;
    end
  end

  // ---------------- output stages ----------------
  wire [NUM_SW-1:0] nxt_sw = sw_cmd & ~oc_off_ff & ~oc_trip
                             & {NUM_SW{awake & ~tsd_ff & ~shut_s}};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      switch_on <= '0;
      stage_drive_en <= 1'b0;
      current_limit_en <= 1'b0;
    end else begin
      switch_on <= nxt_sw;
      stage_drive_en <= awake;
      // the regulator does not look at the shutdown enable bit
      current_limit_en <= awake;
    end
  end

  // ---------------- result data ----------------
  function automatic logic [FRAME_BITS-1:0] status_word(
    input logic tp, input logic [NUM_SW-1:0] sw, input logic short_circuit_flag);
    logic [FRAME_BITS-1:0] w;
    w = '0;
    w[ST_TP_BIT] = tp;
    w[ST_SW_LSB +: NUM_SW] = sw;
    w[ST_SCD_BIT] = short_circuit_flag;
    return w;
  endfunction

  logic [FRAME_BITS-1:0] tx_sh_ff;
  wire [FRAME_BITS-1:0] status_now = status_word(tp_ff, switch_on, scd_ff);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_ff <= '0;
      ser_dout <= 1'b0;
      ser_dout_oe_n <= 1'b1;
    end else begin
      ser_dout_oe_n <= cs_s;
      if (cs_fall) begin
        // snapshot the status so a frame reads one consistent word;
        // the prewarning bit is out before the first serial edge
        tx_sh_ff <= status_now;
        ser_dout <= status_now[ST_TP_BIT];
      end else if (bit_evt && !cs_s) begin
        tx_sh_ff <= {1'b0, tx_sh_ff[FRAME_BITS-1:1]};
        ser_dout <= tx_sh_ff[1];
      end
    end
  end

endmodule

// file: hdl/hb_prot_pkg.sv
// Purpose: shared constants for the half-bridge protection and status block
// Assumes: core clock 25 MHz, serial link clocked by the controller
// Notes: status word bit positions follow the serial result word
package hb_prot_pkg;
  localparam int CORE_CLK_KHZ = 25000;
  localparam int SCLK_MAX_KHZ = 2000;
  localparam int FRAME_BITS = 16;
  localparam int NUM_SW = 6;
  // serial status word fields
  localparam int ST_TP_BIT = 0;
  localparam int ST_SW_LSB = 1;
  localparam int ST_SCD_BIT = 13;
  // control word fields
  localparam int CT_SRR_BIT = 0;
  localparam int CT_SW_LSB = 1;
  localparam int CT_OCS_BIT = 13;
  // control word after internal power-on reset: overcurrent shutdown on
  localparam logic [15:0] CTRL_RST = 16'h2000;
  // overcurrent shutdown delay; no figure fixed, plain default
  localparam int SD_DELAY_NS = 10000;
  localparam int SD_DELAY_CYC_RAW = (SD_DELAY_NS * CORE_CLK_KHZ) / 1000000;
  localparam int SD_DELAY_CYC = (SD_DELAY_CYC_RAW < 1) ? 1 : SD_DELAY_CYC_RAW;
  // internal power-on reset hold after wake-up
  localparam int POR_DELAY_US = 95;
  localparam int POR_DELAY_CYC = POR_DELAY_US * CORE_CLK_KHZ / 1000;
  localparam int SD_CNT_W = $clog2(SD_DELAY_CYC + 1);
  localparam int POR_CNT_W = $clog2(POR_DELAY_CYC + 1);
  localparam int BIT_CNT_W = 5;
endpackage

// file: dv/halfbridge_protection_status_assertions.sv
// Purpose: port-level checks of the protection and status block
// Assumes: core clock only; sim counts SD_CYC 4, POR_CYC 10
// Notes: serial clock is sampled as a level, never used as a clock here
module halfbridge_protection_status_chk
  import hb_prot_pkg::*;
#(
  parameter int SD_CYC = 4,
  parameter int POR_CYC = 10
) (
  input logic core_clk,
  input logic rst_n,
  input logic ser_clk,
  input logic chip_sel_n,
  input logic ser_din,
  input logic ser_dout,
  input logic ser_dout_oe_n,
  input logic sleep_control_pin,
  input logic prewarn_cmp,
  input logic shutdown_cmp,
  input logic [NUM_SW-1:0] overcurrent_cmp,
  input logic [NUM_SW-1:0] switch_on,
  input logic stage_drive_en,
  input logic current_limit_en
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_cs_fall;
    $fell(chip_sel_n);
  endsequence
  sequence s_tp_steady;
    $stable(prewarn_cmp) [*6];
  endsequence
  a_sleep_off: assert property (
    !sleep_control_pin [*5] |-> switch_on == 6'h00 && !stage_drive_en)
    else $error("switches live while asleep");
  a_therm_off: assert property (
    shutdown_cmp [*6] |-> switch_on == 6'h00)
    else $error("switches live while overheated");
  a_limit_on: assert property (
    stage_drive_en |-> current_limit_en)
    else $error("stages driven without current limit");
  a_oe_drive: assert property (
    s_cs_fall ##1 !chip_sel_n [*3] |-> !ser_dout_oe_n)
    else $error("result output not driven after select");
  a_tp_first: assert property (
    s_tp_steady ##0 s_cs_fall ##1 (!chip_sel_n && !ser_clk) [*4]
    |-> ser_dout == prewarn_cmp)
    else $error("first result bit is not the prewarning");
  a_oe_release: assert property (
    $rose(chip_sel_n) |-> ##[2:5] ser_dout_oe_n)
    else $error("result output held after deselect");
  a_oc_delay: assert property (
    $rose(|overcurrent_cmp) ##0 chip_sel_n |-> ##1 $stable(switch_on) [*3])
    else $error("overcurrent trip without delay");
  a_no_selfon: assert property (
    chip_sel_n [*8] ##0 switch_on == 6'h00 |=> switch_on == 6'h00)
    else $error("switch turned on without a frame");
endmodule

// file: dv/hb_host_model.sv
// Purpose: controller model driving the serial link
// Assumes: serial clock idles low and runs only inside frames
// Notes: a refused frame is made by passing fewer than 16 edges
module hb_host_model (
  input wire logic core_clk,
  output logic ser_clk,
  output logic chip_sel_n,
  output logic ser_din,
  input wire logic ser_dout
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] st;
  event done;
  initial begin
    ser_clk = 1'b0;
    chip_sel_n = 1'b1;
    ser_din = 1'b0;
  end
  // each bit is taken just before the next rising edge
  task automatic xfer(input logic [15:0] w, input int n);
    st = 16'h0000;
    @(posedge core_clk) #2;
    chip_sel_n = 1'b0;
    ser_din = w[0];
    #300 st[0] = ser_dout;
    for (int k = 0; k < n; k++) begin
      ser_clk = 1'b1;
      #250 ser_clk = 1'b0;
      ser_din = (k < 15) ? w[k+1] : ~w[k];
      #250 if (k < 15) st[k+1] = ser_dout;
    end
    chip_sel_n = 1'b1;
    ser_din = ~ser_din;
    -> done;
    #400;
  endtask
endmodule

// file: dv/halfbridge_protection_status_test.sv
// Purpose: self-checking bench of the protection and status block
// Assumes: shortened counts SD 4 and POR 10 core cycles
// Notes: status is noted before each frame and checked when it ends
module halfbridge_protection_status_test import hb_prot_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
  localparam int SD = 4, POR = 10;
  logic core_clk, rst_n, sleep_control_pin, prewarn_cmp, shutdown_cmp;
  logic ser_clk, chip_sel_n, ser_din, ser_dout, ser_dout_oe_n, do_ln;
  logic stage_drive_en, current_limit_en;
  logic [NUM_SW-1:0] overcurrent_cmp, switch_on, sw;
  logic [15:0] stv, e, q[$];
  int failures = 0, n_tests = 0;
  // a released result line shows the inverse, never a held value
  assign do_ln = ser_dout_oe_n ? ~ser_dout : ser_dout;
  halfbridge_protection_status #(.SD_CYC(SD), .POR_CYC(POR))
    u_halfbridge_protection_status (.core_clk, .rst_n, .ser_clk,
    .chip_sel_n, .ser_din, .ser_dout, .ser_dout_oe_n, .sleep_control_pin,
    .prewarn_cmp, .shutdown_cmp, .overcurrent_cmp, .switch_on,
    .stage_drive_en, .current_limit_en);
  hb_host_model u_hb_host_model (.core_clk, .ser_clk, .chip_sel_n,
    .ser_din, .ser_dout(do_ln));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic conclude();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic frame(input logic [15:0] w, input int n);
    q.push_back(stv & 16'((17'h1 << (n + 1)) - 17'h1));
    u_hb_host_model.xfer(w, n);
    cyc(6);
  endtask
  task automatic trip(input int len);
    overcurrent_cmp[0] = 1'b1;
    cyc(len);
    overcurrent_cmp[0] = 1'b0;
    cyc(4);
  endtask
  function automatic logic [15:0] cw(logic status_reset_request, logic ocs, logic [5:0] s);
    return {2'b00, ocs, 6'h00, s, status_reset_request};
  endfunction
  initial forever begin
    @(u_hb_host_model.done);
    e = q.pop_front();
    `CHK(u_hb_host_model.st, e)
  end
  initial begin
    #500000 failures++;
    conclude();
  end
  initial begin
    {rst_n, sleep_control_pin, prewarn_cmp, shutdown_cmp} = 4'h0;
    overcurrent_cmp = 6'h00;
    stv = 16'h0000;
    void'($urandom(32'h8F29));
    cyc(4);
    rst_n = 1'b1;
    `CHK({switch_on, stage_drive_en}, 7'h00)
    sleep_control_pin = 1'b1;
    cyc(POR + 10);
    `CHK({stage_drive_en, current_limit_en}, 2'b11)
    sw = 6'($urandom()) | 6'h01;
    frame(cw(1'b0, 1'b1, sw), 16);
    stv[6:1] = sw;
    prewarn_cmp = 1'b1;
    cyc(6);
    stv[0] = 1'b1;
    frame(16'hFFFF, 0);
    frame(16'hFFFF, 8);
    `CHK(switch_on, sw)
    prewarn_cmp = 1'b0;
    cyc(6);
    stv[0] = 1'b0;
    trip(SD - 2);
    `CHK(switch_on, sw)
    trip(SD + 6);
    `CHK(switch_on, sw & 6'h3E)
    stv = {2'b00, 1'b1, 6'h00, sw & 6'h3E, 1'b0};
    frame(cw(1'b1, 1'b0, sw), 16);
    stv = {9'h000, sw, 1'b0};
    `CHK(switch_on, sw)
    trip(SD + 6);
    `CHK(switch_on, sw)
    `CHK(current_limit_en, 1'b1)
    stv[13] = 1'b1;
    frame(cw(1'b1, 1'b1, sw), 16);
    stv[13] = 1'b0;
    shutdown_cmp = 1'b1;
    cyc(6);
    `CHK(switch_on, 6'h00)
    stv[6:1] = 6'h00;
    frame(cw(1'b1, 1'b1, sw), 16);
    shutdown_cmp = 1'b0;
    cyc(6);
    `CHK(switch_on, 6'h00)
    frame(cw(1'b1, 1'b1, sw), 16);
    `CHK(switch_on, sw)
    trip(SD + 6);
    sleep_control_pin = 1'b0;
    cyc(6);
    `CHK({switch_on, stage_drive_en}, 7'h00)
    sleep_control_pin = 1'b1;
    cyc(POR + 10);
    stv = 16'h0000;
    frame(16'h0000, 16);
    cyc(10);
    conclude();
  end
endmodule
bind halfbridge_protection_status halfbridge_protection_status_chk
  #(.SD_CYC(SD_CYC), .POR_CYC(POR_CYC)) u_chk (.*);
